/* File: cpu_state_checker.sv */
module cpu_state_checker #(
	parameter int REG_ADDR_W = 8
) (
	input logic MCLK,
	input logic RST_B,
	input logic CE,
	input logic [REG_ADDR_W-1:0] REG_ADDR,
	input logic REG_WR,
	input logic REG_RD,
	input logic [31:0] REG_RDATA,
	input logic ACCESS_FAULT,
	input logic IP_LOAD,
	input logic [31:0] IP_VALUE,
	input logic [31:0] INSTRUCTION_POINTER,
	input logic FLAG_WE,
	input logic [4:0] FLAG_IN,
	input logic [15:0] PROCESSOR_STATUS_WORD,
	input logic EXC_REQ,
	input logic VEC_VALID,
	input logic ACC_VALID,
	input logic ACC_CPU,
	input logic ACC_DONE,
	input logic [2:0] SPACE_CODE,
	input logic PTR_REQ,
	input logic [31:0] PTR_ADDR,
	input logic PTR_ACK
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_B);
	chk_read_idle_zero: assert property (CE && !REG_RD |=> REG_RDATA == 32'h0000_0000)
		else $error("read data not zero outside a read answer");
	chk_user_fault: assert property (CE && (REG_WR || REG_RD) && !PROCESSOR_STATUS_WORD[13]
		&& REG_ADDR != REG_ADDR_W'(cpu_state_pkg::OFS_PSW) |=> ACCESS_FAULT)
		else $error("user access to a privileged register not refused");
	chk_super_no_fault: assert property (CE && PROCESSOR_STATUS_WORD[13] |=> !ACCESS_FAULT)
		else $error("supervisor access refused");
	chk_ip_load: assert property (CE && IP_LOAD |=> INSTRUCTION_POINTER == $past(IP_VALUE))
		else $error("instruction pointer load lost");
	chk_flag_write: assert property (CE && FLAG_WE |=> PROCESSOR_STATUS_WORD[4:0] == $past(FLAG_IN))
		else $error("condition flags not updated");
	chk_exc_enter: assert property (CE && EXC_REQ |=> PROCESSOR_STATUS_WORD[15:13] == 3'h1 && VEC_VALID)
		else $error("exception entry state wrong");
	chk_vec_cause: assert property (VEC_VALID |-> $past(CE && EXC_REQ))
		else $error("vector fetch without exception");
	chk_cpu_space: assert property (CE && ACC_VALID && ACC_CPU |=> ACC_DONE && SPACE_CODE == 3'h7)
		else $error("processor space code wrong");
	chk_ptr_hold: assert property (PTR_REQ && !PTR_ACK |=> PTR_REQ && $stable(PTR_ADDR))
		else $error("pointer fetch request dropped or changed");
endmodule

bind cpu_state_core cpu_state_checker #(.REG_ADDR_W(REG_ADDR_W)) u_checker (.*);

/* File: cpu_state_core.sv */
module cpu_state_core #(
	parameter int REG_ADDR_W = 8,
	parameter logic [2:0] CODE_USER_DATA = 3'h1,
	parameter logic [2:0] CODE_USER_PROG = 3'h2,
	parameter logic [2:0] CODE_SUP_DATA = 3'h5,
	parameter logic [2:0] CODE_SUP_PROG = 3'h6,
	parameter logic [2:0] CODE_CPU = 3'h7
) (
	input logic MCLK,
	input logic RST_B,
	input logic CE,
	input logic [REG_ADDR_W-1:0] REG_ADDR,
	input logic [31:0] REG_WDATA,
	input logic REG_WR,
	input logic REG_RD,
	output logic [31:0] REG_RDATA,
	output logic ACCESS_FAULT,
	input logic IP_ADVANCE,
	input logic [3:0] IP_STEP,
	input logic IP_LOAD,
	input logic [31:0] IP_VALUE,
	output logic [31:0] INSTRUCTION_POINTER,
	input logic FLAG_WE,
	input logic [4:0] FLAG_IN,
	input logic [3:0] COND_SEL,
	output logic COND_TRUE,
	output logic [15:0] PROCESSOR_STATUS_WORD,
	input logic EXC_REQ,
	input logic [15:0] EXC_DISP,
	output logic [31:0] VEC_ADDR,
	output logic VEC_VALID,
	input logic ACC_VALID,
	input logic [31:0] ACC_ADDR,
	input logic ACC_WRITE,
	input logic ACC_PROG,
	input logic ACC_CPU,
	input logic ACC_USE_SRC,
	input logic ACC_USE_DST,
	output logic ACC_DONE,
	output logic [2:0] SPACE_CODE,
	output logic TRANSPARENT_HIT,
	output logic TRANSLATE,
	output logic [63:0] TABLE_ROOT,
	output logic [31:0] TRANSLATION_CONTROL,
	input logic STATUS_WE,
	input logic [15:0] STATUS_IN,
	input logic EA_REQ_VALID,
	input cpu_state_pkg::ea_req_t EA_REQ,
	output logic PTR_REQ,
	output logic [31:0] PTR_ADDR,
	input logic PTR_ACK,
	input logic [31:0] PTR_DATA,
	output logic EA_VALID,
	output cpu_state_pkg::ea_res_t EA_RES
);
	generate
		if (REG_ADDR_W < 6 || REG_ADDR_W > 8)
			$error("REG_ADDR_W must lie between 6 and 8");
	endgenerate

	logic [31:0] ip_q, vbr_q, tc_q;
	logic [15:0] psw_q, translation_status_q;
	logic [2:0] sfc_q, dfc_q;
	logic [63:0] crp_q, srp_q;
	logic [31:0] win_q [2];
	logic [1:0] win_hit;
	logic [7:0] addr_sel;
	logic sup, priv_ok, psw_sel;
	logic wr_ok, rd_ok;
	logic [2:0] acc_space;
	logic cond;
	logic [31:0] rd_d;
	logic [31:0] rdata_q, vec_addr_q;
	logic fault_q, vec_valid_q, cond_q;
	logic acc_done_q, hit_q, translate_q;
	logic [2:0] space_q;
	logic [63:0] root_q;
	logic flag_x, flag_n, flag_z, flag_v, flag_c;

	always_comb begin
		addr_sel = 8'h00;
		addr_sel[REG_ADDR_W-1:0] = REG_ADDR;
		sup = psw_q[cpu_state_pkg::PSW_S];
		psw_sel = addr_sel == cpu_state_pkg::OFS_PSW;
		// user code may touch nothing but the flag byte
		priv_ok = sup | psw_sel;
		wr_ok = REG_WR & priv_ok;
		rd_ok = REG_RD & priv_ok;
	end

	// instruction pointer: a load beats an advance, both beat a software write
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			ip_q <= cpu_state_pkg::WORD_RESET;
		end else if (CE) begin
			if (IP_LOAD)
				ip_q <= IP_VALUE;
			else if (IP_ADVANCE)
				ip_q <= ip_q + {28'h000_0000, IP_STEP};
			else if (wr_ok && addr_sel == cpu_state_pkg::OFS_IP)
				ip_q <= REG_WDATA;
		end
	end

	// status word; fresh flags from the datapath win over a software write
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			psw_q <= cpu_state_pkg::PSW_RESET;
		end else if (CE) begin
			if (REG_WR && psw_sel) begin
				if (sup)
					psw_q <= REG_WDATA[15:0];
				else
					psw_q[4:0] <= REG_WDATA[4:0];
			end
			if (EXC_REQ) begin
				psw_q[cpu_state_pkg::PSW_S] <= 1'b1;
				psw_q[cpu_state_pkg::PSW_T1] <= 1'b0;
				psw_q[cpu_state_pkg::PSW_T0] <= 1'b0;
			end
			if (FLAG_WE)
				psw_q[4:0] <= FLAG_IN;
		end
	end

	// the remaining control registers are supervisor only
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			vbr_q <= cpu_state_pkg::WORD_RESET;
			sfc_q <= 3'h0;
			dfc_q <= 3'h0;
			crp_q <= cpu_state_pkg::ROOT_RESET;
			srp_q <= cpu_state_pkg::ROOT_RESET;
			tc_q <= cpu_state_pkg::WORD_RESET;
		end else if (CE && wr_ok) begin
			case (addr_sel)
				cpu_state_pkg::OFS_VBR: vbr_q <= REG_WDATA;
				cpu_state_pkg::OFS_SFC: sfc_q <= REG_WDATA[2:0];
				cpu_state_pkg::OFS_DFC: dfc_q <= REG_WDATA[2:0];
				cpu_state_pkg::OFS_CRP_HI: crp_q[63:32] <= REG_WDATA;
				cpu_state_pkg::OFS_CRP_LO: crp_q[31:0] <= REG_WDATA;
				cpu_state_pkg::OFS_SRP_HI: srp_q[63:32] <= REG_WDATA;
				cpu_state_pkg::OFS_SRP_LO: srp_q[31:0] <= REG_WDATA;
				cpu_state_pkg::OFS_TC: tc_q <= REG_WDATA;
				default: ;
			endcase
		end
	end

	// two transparent windows, one matcher each
	generate
		for (genvar w = 0; w < 2; w++) begin : g_win
			always_ff @(posedge MCLK) begin
				if (!RST_B)
					win_q[w] <= cpu_state_pkg::WORD_RESET;
				else if (CE && wr_ok && addr_sel == (cpu_state_pkg::OFS_WIN0 + 8'(4 * w)))
					win_q[w] <= REG_WDATA;
			end
			window_match u_match (
				.window(win_q[w]),
				.addr_top(ACC_ADDR[31:24]),
				.space(acc_space),
				.write(ACC_WRITE),
				.hit(win_hit[w])
			);
		end
	endgenerate

	// a search result from the table walker wins over software in the same cycle
	always_ff @(posedge MCLK) begin
		if (!RST_B)
			translation_status_q <= 16'h0000;
		else if (CE) begin
			if (STATUS_WE)
				translation_status_q <= STATUS_IN;
			else if (wr_ok && addr_sel == cpu_state_pkg::OFS_TRANSLATION_STATUS)
				translation_status_q <= REG_WDATA[15:0];
		end
	end

	always_comb begin
		rd_d = cpu_state_pkg::WORD_RESET;
		case (addr_sel)
			cpu_state_pkg::OFS_IP: rd_d = ip_q;
			cpu_state_pkg::OFS_PSW: rd_d = {16'h0000, sup ? psw_q : (psw_q & cpu_state_pkg::PSW_USER_MASK)};
			cpu_state_pkg::OFS_VBR: rd_d = vbr_q;
			cpu_state_pkg::OFS_SFC: rd_d = {29'h0000_0000, sfc_q};
			cpu_state_pkg::OFS_DFC: rd_d = {29'h0000_0000, dfc_q};
			cpu_state_pkg::OFS_CRP_HI: rd_d = crp_q[63:32];
			cpu_state_pkg::OFS_CRP_LO: rd_d = crp_q[31:0];
			cpu_state_pkg::OFS_SRP_HI: rd_d = srp_q[63:32];
			cpu_state_pkg::OFS_SRP_LO: rd_d = srp_q[31:0];
			cpu_state_pkg::OFS_TC: rd_d = tc_q;
			cpu_state_pkg::OFS_WIN0: rd_d = win_q[0];
			cpu_state_pkg::OFS_WIN1: rd_d = win_q[1];
			cpu_state_pkg::OFS_TRANSLATION_STATUS: rd_d = {16'h0000, translation_status_q};
			default: rd_d = cpu_state_pkg::WORD_RESET;
		endcase
	end

	// read data stands for one cycle only; refused reads give zero and a fault pulse
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			rdata_q <= cpu_state_pkg::WORD_RESET;
			fault_q <= 1'b0;
		end else if (CE) begin
			rdata_q <= rd_ok ? rd_d : cpu_state_pkg::WORD_RESET;
			fault_q <= (REG_WR | REG_RD) & ~priv_ok;
		end
	end

	// displacement is unsigned: the table never sits below its base
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			vec_addr_q <= cpu_state_pkg::WORD_RESET;
			vec_valid_q <= 1'b0;
		end else if (CE) begin
			vec_valid_q <= EXC_REQ;
			if (EXC_REQ)
				vec_addr_q <= vbr_q + {16'h0000, EXC_DISP};
		end
	end

	always_comb begin
		flag_x = psw_q[cpu_state_pkg::PSW_X];
		flag_n = psw_q[cpu_state_pkg::PSW_N];
		flag_z = psw_q[cpu_state_pkg::PSW_Z];
		flag_v = psw_q[cpu_state_pkg::PSW_V];
		flag_c = psw_q[cpu_state_pkg::PSW_C];
		case (COND_SEL)
			4'h0: cond = 1'b1;
			4'h1: cond = 1'b0;
			4'h2: cond = ~flag_c & ~flag_z;
			4'h3: cond = flag_c | flag_z;
			4'h4: cond = ~flag_c;
			4'h5: cond = flag_c;
			4'h6: cond = ~flag_z;
			4'h7: cond = flag_z;
			4'h8: cond = ~flag_v;
			4'h9: cond = flag_v;
			4'hA: cond = ~flag_n;
			4'hB: cond = flag_n;
			4'hC: cond = ~(flag_n ^ flag_v);
			4'hD: cond = flag_n ^ flag_v;
			4'hE: cond = ~flag_z & ~(flag_n ^ flag_v);
			default: cond = flag_z | (flag_n ^ flag_v);
		endcase
		// extend takes part in no test; it only carries between multiword steps
		if (flag_x && COND_SEL == 4'h1)
			cond = 1'b0;
	end

	always_ff @(posedge MCLK) begin
		if (!RST_B)
			cond_q <= 1'b0;
		else if (CE)
			cond_q <= cond;
	end

	always_comb begin
		if (ACC_CPU)
			acc_space = CODE_CPU;
		else if (ACC_USE_SRC)
			acc_space = sfc_q;
		else if (ACC_USE_DST)
			acc_space = dfc_q;
		else if (sup)
			acc_space = ACC_PROG ? CODE_SUP_PROG : CODE_SUP_DATA;
		else
			acc_space = ACC_PROG ? CODE_USER_PROG : CODE_USER_DATA;
	end

	// one result per access, held until the next access
	always_ff @(posedge MCLK) begin
		if (!RST_B) begin
			acc_done_q <= 1'b0;
			space_q <= 3'h0;
			hit_q <= 1'b0;
			translate_q <= 1'b0;
			root_q <= cpu_state_pkg::ROOT_RESET;
		end else if (CE) begin
			acc_done_q <= ACC_VALID;
			if (ACC_VALID) begin
				space_q <= acc_space;
				hit_q <= |win_hit;
				translate_q <= tc_q[cpu_state_pkg::TC_EN] & ~(|win_hit);
				if (tc_q[cpu_state_pkg::TC_SRE] && acc_space[2])
					root_q <= srp_q;
				else
					root_q <= crp_q;
			end
		end
	end

	ea_gen u_ea (
		.clk(MCLK),
		.rst_b(RST_B),
		.ce(CE),
		.req_valid(EA_REQ_VALID),
		.req(EA_REQ),
		.ptr_req(PTR_REQ),
		.ptr_addr(PTR_ADDR),
		.ptr_ack(PTR_ACK),
		.ptr_data(PTR_DATA),
		.res_valid(EA_VALID),
		.res(EA_RES)
	);

	assign REG_RDATA = rdata_q;
	assign ACCESS_FAULT = fault_q;
	assign INSTRUCTION_POINTER = ip_q;
	assign COND_TRUE = cond_q;
	assign PROCESSOR_STATUS_WORD = psw_q;
	assign VEC_ADDR = vec_addr_q;
	assign VEC_VALID = vec_valid_q;
	assign ACC_DONE = acc_done_q;
	assign SPACE_CODE = space_q;
	assign TRANSPARENT_HIT = hit_q;
	assign TRANSLATE = translate_q;
	assign TABLE_ROOT = root_q;
	assign TRANSLATION_CONTROL = tc_q;
endmodule

/* File: cpu_state_core_test.sv */
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("mismatch at %0t got %h exp %h", $time, (a), (b)); end end
module cpu_state_core_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic MCLK = 0, RST_B = 0, CE = 1, REG_WR = 0, REG_RD = 0, IP_ADVANCE = 0, IP_LOAD = 0;
	logic FLAG_WE = 0, EXC_REQ = 0, ACC_VALID = 0, ACC_WRITE = 0, ACC_PROG = 0, ACC_CPU = 0;
	logic ACC_USE_SRC = 0, ACC_USE_DST = 0, STATUS_WE = 0, EA_REQ_VALID = 0, PTR_ACK = 0;
	logic [7:0] REG_ADDR = 0;
	logic [31:0] REG_WDATA = 0, IP_VALUE = 0, ACC_ADDR = 0, PTR_DATA = 0;
	logic [3:0] IP_STEP = 0, COND_SEL = 0;
	logic [4:0] FLAG_IN = 0;
	logic [15:0] EXC_DISP = 0, STATUS_IN = 0;
	cpu_state_pkg::ea_req_t EA_REQ = '0;
	logic [31:0] REG_RDATA, INSTRUCTION_POINTER, VEC_ADDR, TRANSLATION_CONTROL, PTR_ADDR;
	logic ACCESS_FAULT, COND_TRUE, VEC_VALID, ACC_DONE, TRANSPARENT_HIT, TRANSLATE, PTR_REQ, EA_VALID;
	logic [15:0] PROCESSOR_STATUS_WORD;
	logic [2:0] SPACE_CODE;
	logic [63:0] TABLE_ROOT;
	cpu_state_pkg::ea_res_t EA_RES;
	int n_mismatch = 0, cmp_count = 0, cycles = 0;
	cpu_state_core DUT (.*);
	always #25 MCLK = ~MCLK;
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// run is a few hundred cycles; ceiling leaves wide margin
	always @(posedge MCLK) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	function automatic logic [31:0] sx16(input logic [15:0] d);
		return {{16{d[15]}}, d};
	endfunction
	function automatic logic cond(input int c, input logic [4:0] f);
		logic n, z, v, cy;
		logic [15:0] t;
		{n, z, v, cy} = f[3:0];
		t = {z | (n ^ v), ~z & ~(n ^ v), n ^ v, ~(n ^ v), n, ~n, v, ~v, z, ~z, cy, ~cy, cy | z, ~cy & ~z, 2'b01};
		return t[c];
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge MCLK);
		REG_WR <= 1'b0;
		#1;
	endtask
	task automatic expect_rd(input logic [7:0] a, input logic [31:0] e, input logic fe);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_RD <= 1'b1;
		@(posedge MCLK);
		REG_RD <= 1'b0;
		#1 `CHK(REG_RDATA, e)
		`CHK(ACCESS_FAULT, fe)
	endtask
	task automatic exc(input logic [15:0] d);
		@(posedge MCLK);
		EXC_REQ <= 1'b1;
		EXC_DISP <= d;
		@(posedge MCLK);
		EXC_REQ <= 1'b0;
		#1;
	endtask
	task automatic acc(input logic [31:0] a, input logic [4:0] k, input logic [2:0] sp, input logic hit,
		input logic tr);
		@(posedge MCLK);
		ACC_ADDR <= a;
		{ACC_WRITE, ACC_PROG, ACC_CPU, ACC_USE_SRC, ACC_USE_DST} <= k;
		ACC_VALID <= 1'b1;
		@(posedge MCLK);
		ACC_VALID <= 1'b0;
		#1 `CHK(ACC_DONE, 1'b1)
		`CHK(SPACE_CODE, sp)
		`CHK(TRANSPARENT_HIT, hit)
		`CHK(TRANSLATE, tr)
	endtask
	// pointer data is scrambled outside the acknowledge cycle so a stale read shows
	task automatic ea(input cpu_state_pkg::ea_req_t r, input logic [31:0] p, input logic [31:0] mid,
		input logic [31:0] e, input logic err);
		logic acked, ack_next, got;
		acked = 0;
		ack_next = 0;
		got = 0;
		@(posedge MCLK);
		EA_REQ <= r;
		EA_REQ_VALID <= 1'b1;
		PTR_DATA <= ~p;
		@(posedge MCLK);
		EA_REQ_VALID <= 1'b0;
		for (int i = 0; i < 12 && !got; i++) begin
			#1;
			if (EA_VALID === 1'b1) got = 1;
			else if (PTR_REQ === 1'b1 && !acked) begin
				`CHK(PTR_ADDR, mid)
				acked = 1;
				ack_next = 1;
			end
			if (!got) begin
				@(posedge MCLK);
				PTR_ACK <= ack_next;
				PTR_DATA <= ack_next ? p : ~p;
				ack_next = 0;
			end
		end
		`CHK(got, 1'b1)
		`CHK(EA_RES.error, err)
		if (!err) `CHK(EA_RES.addr, e)
	endtask
	initial begin
		logic [31:0] v, w, xs, bd, od, p;
		cpu_state_pkg::ea_req_t r;
		void'($urandom(32'hd64b));
		repeat (10) @(posedge MCLK);
		RST_B <= 1'b1;
		#1 `CHK(PROCESSOR_STATUS_WORD, 16'h2700)
		`CHK(INSTRUCTION_POINTER, 32'h0000_0000)
		v = $urandom;
		w = $urandom;
		wr(cpu_state_pkg::OFS_VBR, v);
		expect_rd(cpu_state_pkg::OFS_VBR, v, 1'b0);
		wr(cpu_state_pkg::OFS_SFC, 32'hFFFF_FFFD);
		expect_rd(cpu_state_pkg::OFS_SFC, 32'h0000_0005, 1'b0);
		wr(cpu_state_pkg::OFS_DFC, 32'h0000_0003);
		expect_rd(8'h40, 32'h0000_0000, 1'b0);
		@(posedge MCLK);
		STATUS_WE <= 1'b1;
		STATUS_IN <= 16'($urandom);
		@(posedge MCLK);
		STATUS_WE <= 1'b0;
		expect_rd(cpu_state_pkg::OFS_TRANSLATION_STATUS, {16'h0000, STATUS_IN}, 1'b0);
		exc(w[15:0]);
		`CHK(VEC_ADDR, v + {16'h0000, w[15:0]})
		@(posedge MCLK);
		{IP_LOAD, IP_ADVANCE, IP_STEP, IP_VALUE} <= {2'b11, 4'hA, w};
		@(posedge MCLK);
		IP_LOAD <= 1'b0;
		@(posedge MCLK);
		IP_ADVANCE <= 1'b0;
		#1 `CHK(INSTRUCTION_POINTER, w + 32'h0000_000A)
		// clock enable low must freeze the pointer even with an advance pending
		@(posedge MCLK);
		{CE, IP_ADVANCE, IP_STEP} <= {2'b01, 4'h4};
		@(posedge MCLK);
		{CE, IP_ADVANCE} <= 2'b10;
		#1 `CHK(INSTRUCTION_POINTER, w + 32'h0000_000A)
		for (int c = 0; c < 16; c++) begin
			@(posedge MCLK);
			{FLAG_WE, FLAG_IN, COND_SEL} <= {1'b1, 5'($urandom), 4'(c)};
			@(posedge MCLK);
			FLAG_WE <= 1'b0;
			@(posedge MCLK);
			#1 `CHK(PROCESSOR_STATUS_WORD[4:0], FLAG_IN)
			`CHK(COND_TRUE, cond(c, FLAG_IN))
		end
		$display("test state done");
		wr(cpu_state_pkg::OFS_CRP_LO, v);
		wr(cpu_state_pkg::OFS_SRP_LO, w);
		wr(cpu_state_pkg::OFS_TC, 32'h8200_0000);
		`CHK(TRANSLATION_CONTROL, 32'h8200_0000)
		acc(32'h1234_0000, 5'b00000, 3'h5, 1'b0, 1'b1);
		`CHK(TABLE_ROOT, {32'h0000_0000, w})
		acc(32'h1234_0000, 5'b01000, 3'h6, 1'b0, 1'b1);
		acc(32'h1234_0000, 5'b00100, 3'h7, 1'b0, 1'b1);
		acc(32'h1234_0000, 5'b00010, 3'h5, 1'b0, 1'b1);
		acc(32'h1234_0000, 5'b00001, 3'h3, 1'b0, 1'b1);
		`CHK(TABLE_ROOT, {32'h0000_0000, v})
		wr(cpu_state_pkg::OFS_WIN0, 32'h4000_8107);
		wr(cpu_state_pkg::OFS_WIN1, 32'h6000_8007);
		acc(32'h40AB_CDEF, 5'b00000, 3'h5, 1'b1, 1'b0);
		acc(32'h40AB_CDEF, 5'b10000, 3'h5, 1'b1, 1'b0);
		acc(32'h6000_0010, 5'b00000, 3'h5, 1'b0, 1'b1);
		acc(32'h6000_0010, 5'b10000, 3'h5, 1'b1, 1'b0);
		wr(cpu_state_pkg::OFS_WIN1, 32'h6000_8207);
		acc(32'h6000_0010, 5'b00000, 3'h5, 1'b1, 1'b0);
		acc(32'h6000_0010, 5'b10000, 3'h5, 1'b0, 1'b1);
		wr(cpu_state_pkg::OFS_PSW, 32'h0000_0000);
		acc(32'h1234_0000, 5'b01000, 3'h2, 1'b0, 1'b1);
		expect_rd(cpu_state_pkg::OFS_VBR, 32'h0000_0000, 1'b1);
		wr(cpu_state_pkg::OFS_PSW, 32'h0000_FFFF);
		expect_rd(cpu_state_pkg::OFS_PSW, 32'h0000_001F, 1'b0);
		exc(16'h0010);
		`CHK(PROCESSOR_STATUS_WORD, 16'h201F)
		wr(cpu_state_pkg::OFS_PSW, 32'h0000_C71F);
		`CHK(PROCESSOR_STATUS_WORD, 16'hC71F)
		exc(16'h0020);
		`CHK(PROCESSOR_STATUS_WORD, 16'h271F)
		$display("test spaces done");
		for (int k = 0; k < 4; k++) begin
			r = '0;
			{r.areg, r.pc, r.index, p} = {$urandom, $urandom, $urandom, $urandom};
			{r.scale, r.index_long} = 3'($urandom);
			r.size = cpu_state_pkg::SZ_LONG;
			r.field_width = 6'h08;
			{r.base_disp.value, r.outer_disp.value} = {$urandom, $urandom};
			r.base_disp.size = cpu_state_pkg::DS_32;
			r.outer_disp.size = cpu_state_pkg::DS_16;
			xs = (r.index_long ? r.index : sx16(r.index[15:0])) << r.scale;
			bd = r.base_disp.value;
			od = sx16(r.outer_disp.value[15:0]);
			r.mode = cpu_state_pkg::M_IDXBD;
			ea(r, p, 0, r.areg + bd + xs, 1'b0);
			r.mode = cpu_state_pkg::M_MI_POST;
			ea(r, p, r.areg + bd, p + xs + od, 1'b0);
			r.mode = cpu_state_pkg::M_MI_PRE;
			ea(r, p, r.areg + bd + xs, p + od, 1'b0);
			r.mode = cpu_state_pkg::M_PC_MI_POST;
			ea(r, p, r.pc + bd, p + xs + od, 1'b0);
			r.mode = cpu_state_pkg::M_DISP16;
			ea(r, p, 0, r.areg + sx16(bd[15:0]), 1'b0);
			r.mode = cpu_state_pkg::M_PC_IDX8;
			ea(r, p, 0, r.pc + {{24{bd[7]}}, bd[7:0]} + xs, 1'b0);
			r.mode = cpu_state_pkg::M_ABS_W;
			ea(r, p, 0, sx16(bd[15:0]), 1'b0);
			r.mode = cpu_state_pkg::M_IMM;
			ea(r, p, 0, r.pc, 1'b0);
			r.mode = cpu_state_pkg::M_POSTINC;
			ea(r, p, 0, r.areg, 1'b0);
			`CHK(EA_RES.areg_new, r.areg + 32'h0000_0004)
			`CHK(EA_RES.areg_wb, 1'b1)
			r.size = cpu_state_pkg::SZ_BCD_PACKED;
			ea(r, p, 0, r.areg, 1'b0);
			`CHK(EA_RES.bytes, 4'h1)
			`CHK(EA_RES.areg_new, r.areg + 32'h0000_0001)
			r.mode = cpu_state_pkg::M_PREDEC;
			r.size = cpu_state_pkg::SZ_WORD;
			ea(r, p, 0, r.areg - 32'h0000_0002, 1'b0);
			r.mode = cpu_state_pkg::M_IMM;
			r.size = cpu_state_pkg::SZ_QUAD;
			ea(r, p, 0, 0, 1'b1);
			r.mode = cpu_state_pkg::M_IND;
			r.size = cpu_state_pkg::SZ_FIELD;
			r.field_width = 6'h00;
			ea(r, p, 0, 0, 1'b1);
		end
		$display("test addressing done");
		print_verdict();
	end
endmodule

/* File: cpu_state_pkg.sv */
package cpu_state_pkg;
	// register offsets on the software port
	localparam logic [7:0] OFS_IP = 8'h00;
	localparam logic [7:0] OFS_PSW = 8'h04;
	localparam logic [7:0] OFS_VBR = 8'h08;
	localparam logic [7:0] OFS_SFC = 8'h0C;
	localparam logic [7:0] OFS_DFC = 8'h10;
	localparam logic [7:0] OFS_CRP_HI = 8'h14;
	localparam logic [7:0] OFS_CRP_LO = 8'h18;
	localparam logic [7:0] OFS_SRP_HI = 8'h1C;
	localparam logic [7:0] OFS_SRP_LO = 8'h20;
	localparam logic [7:0] OFS_TC = 8'h24;
	localparam logic [7:0] OFS_WIN0 = 8'h28;
	localparam logic [7:0] OFS_WIN1 = 8'h2C;
	localparam logic [7:0] OFS_TRANSLATION_STATUS = 8'h30;
	// status word fields
	localparam int PSW_C = 0;
	localparam int PSW_V = 1;
	localparam int PSW_Z = 2;
	localparam int PSW_N = 3;
	localparam int PSW_X = 4;
	localparam int PSW_IPM_LO = 8;
	localparam int PSW_M = 12;
	localparam int PSW_S = 13;
	localparam int PSW_T0 = 14;
	localparam int PSW_T1 = 15;
	localparam logic [15:0] PSW_RESET = 16'h2700;
	localparam logic [15:0] PSW_USER_MASK = 16'h001F;
	// translation control fields
	localparam int TC_EN = 31;
	localparam int TC_SRE = 25;
	localparam int TC_FCL = 24;
	localparam int TC_PS_LO = 20;
	localparam int TC_IS_LO = 16;
	// transparent window fields
	localparam int WIN_BASE_LO = 24;
	localparam int WIN_MASK_LO = 16;
	localparam int WIN_EN = 15;
	localparam int WIN_RW = 9;
	localparam int WIN_RWM = 8;
	localparam int WIN_FC_BASE_LO = 4;
	localparam int WIN_FC_MASK_LO = 0;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [63:0] ROOT_RESET = 64'h0000_0000_0000_0000;

	typedef enum logic [4:0] {
		M_DREG, M_AREG, M_IND, M_POSTINC, M_PREDEC, M_DISP16, M_IDX8, M_IDXBD,
		M_MI_POST, M_MI_PRE, M_PC_DISP16, M_PC_IDX8, M_PC_IDXBD, M_PC_MI_POST,
		M_PC_MI_PRE, M_ABS_W, M_ABS_L, M_IMM
	} ea_mode_t;
	typedef enum logic [2:0] {
		SZ_BIT, SZ_BYTE, SZ_WORD, SZ_LONG, SZ_QUAD, SZ_FIELD, SZ_BCD_PACKED, SZ_BCD_UNPACKED
	} op_size_t;
	typedef enum logic [1:0] {DS_NONE, DS_8, DS_16, DS_32} disp_size_t;
	typedef struct packed {
		logic [31:0] value;
		disp_size_t size;
	} disp_t;
	typedef struct packed {
		ea_mode_t mode;
		op_size_t size;
		logic [5:0] field_width;
		logic [31:0] areg;
		logic [31:0] pc;
		logic [31:0] index;
		logic index_long;
		logic [1:0] scale;
		disp_t base_disp;
		disp_t outer_disp;
	} ea_req_t;
	typedef struct packed {
		logic [31:0] addr;
		logic reg_direct;
		logic areg_wb;
		logic [31:0] areg_new;
		logic [3:0] bytes;
		logic error;
	} ea_res_t;

	function automatic logic [31:0] ext_disp(input disp_t d);
		case (d.size)
			DS_8: ext_disp = {{24{d.value[7]}}, d.value[7:0]};
			DS_16: ext_disp = {{16{d.value[15]}}, d.value[15:0]};
			DS_32: ext_disp = d.value;
			default: ext_disp = WORD_RESET;
		endcase
	endfunction

	// bcd packed holds two digits per byte, unpacked one; both move a byte
	function automatic logic [3:0] op_bytes(input op_size_t s);
		case (s)
			SZ_WORD: op_bytes = 4'h2;
			SZ_LONG, SZ_FIELD: op_bytes = 4'h4;
			SZ_QUAD: op_bytes = 4'h8;
			default: op_bytes = 4'h1;
		endcase
	endfunction
endpackage

/* File: ea_gen.sv */
module ea_gen (
	input logic clk,
	input logic rst_b,
	input logic ce,
	input logic req_valid,
	input cpu_state_pkg::ea_req_t req,
	output logic ptr_req,
	output logic [31:0] ptr_addr,
	input logic ptr_ack,
	input logic [31:0] ptr_data,
	output logic res_valid,
	output cpu_state_pkg::ea_res_t res
);
	typedef enum {S_IDLE, S_FETCH} ea_state_t;
	ea_state_t state_q;
	logic [31:0] idx, scaled, base, bd, od, inter, post_add, step;
	logic indirect, post_idx, pc_rel, bad;
	logic [31:0] post_q;
	cpu_state_pkg::ea_res_t res_q;
	logic res_valid_q, ptr_req_q;
	logic [31:0] ptr_addr_q;

	always_comb begin
		idx = req.index_long ? req.index : {{16{req.index[15]}}, req.index[15:0]};
		scaled = idx << req.scale;
		pc_rel = req.mode inside {cpu_state_pkg::M_PC_DISP16, cpu_state_pkg::M_PC_IDX8,
			cpu_state_pkg::M_PC_IDXBD, cpu_state_pkg::M_PC_MI_POST, cpu_state_pkg::M_PC_MI_PRE};
		base = pc_rel ? req.pc : req.areg;
		bd = cpu_state_pkg::ext_disp(req.base_disp);
		od = cpu_state_pkg::ext_disp(req.outer_disp);
		step = {28'h000_0000, cpu_state_pkg::op_bytes(req.size)};
		indirect = 1'b0;
		post_idx = 1'b0;
		bad = 1'b0;
		inter = base;
		case (req.mode)
			cpu_state_pkg::M_PREDEC: inter = base - step;
			cpu_state_pkg::M_DISP16, cpu_state_pkg::M_PC_DISP16:
				inter = base + {{16{req.base_disp.value[15]}}, req.base_disp.value[15:0]};
			cpu_state_pkg::M_IDX8, cpu_state_pkg::M_PC_IDX8:
				inter = base + {{24{req.base_disp.value[7]}}, req.base_disp.value[7:0]} + scaled;
			cpu_state_pkg::M_IDXBD, cpu_state_pkg::M_PC_IDXBD: begin
				inter = base + bd + scaled;
				bad = req.base_disp.size == cpu_state_pkg::DS_8;
			end
			cpu_state_pkg::M_MI_POST, cpu_state_pkg::M_PC_MI_POST: begin
				inter = base + bd;
				indirect = 1'b1;
				post_idx = 1'b1;
			end
			cpu_state_pkg::M_MI_PRE, cpu_state_pkg::M_PC_MI_PRE: begin
				inter = base + bd + scaled;
				indirect = 1'b1;
			end
			cpu_state_pkg::M_ABS_W: inter = {{16{req.base_disp.value[15]}}, req.base_disp.value[15:0]};
			cpu_state_pkg::M_ABS_L: inter = req.base_disp.value;
			cpu_state_pkg::M_IMM: begin
				inter = req.pc;
				bad = !(req.size inside {cpu_state_pkg::SZ_BYTE, cpu_state_pkg::SZ_WORD,
					cpu_state_pkg::SZ_LONG});
			end
			default: inter = base;
		endcase
		if (indirect && req.outer_disp.size == cpu_state_pkg::DS_8)
			bad = 1'b1;
		if (req.size == cpu_state_pkg::SZ_FIELD && (req.field_width == 6'h00 || req.field_width > 6'h20))
			bad = 1'b1;
		post_add = od + (post_idx ? scaled : 32'h0000_0000);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q <= S_IDLE;
			ptr_req_q <= 1'b0;
			ptr_addr_q <= cpu_state_pkg::WORD_RESET;
			post_q <= cpu_state_pkg::WORD_RESET;
			res_valid_q <= 1'b0;
			res_q <= '0;
		end else if (ce) begin
			res_valid_q <= 1'b0;
			case (state_q)
				S_IDLE: if (req_valid) begin
					res_q.addr <= inter;
					res_q.reg_direct <= req.mode inside {cpu_state_pkg::M_DREG, cpu_state_pkg::M_AREG};
					res_q.areg_wb <= req.mode inside {cpu_state_pkg::M_POSTINC, cpu_state_pkg::M_PREDEC};
					res_q.areg_new <= (req.mode == cpu_state_pkg::M_POSTINC) ? base + step : inter;
					res_q.bytes <= cpu_state_pkg::op_bytes(req.size);
					res_q.error <= bad;
					if (indirect && !bad) begin
						ptr_req_q <= 1'b1;
						ptr_addr_q <= inter;
						post_q <= post_add;
						state_q <= S_FETCH;
					end else begin
						res_valid_q <= 1'b1;
					end
				end
				S_FETCH: if (ptr_ack) begin
					ptr_req_q <= 1'b0;
					res_q.addr <= ptr_data + post_q;
					res_valid_q <= 1'b1;
					state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	assign ptr_req = ptr_req_q;
	assign ptr_addr = ptr_addr_q;
	assign res_valid = res_valid_q;
	assign res = res_q;
endmodule

/* File: window_match.sv */
module window_match (
	input logic [31:0] window,
	input logic [7:0] addr_top,
	input logic [2:0] space,
	input logic write,
	output logic hit
);
	logic [7:0] base, mask;
	logic [2:0] fc_base, fc_mask;
	logic addr_ok, fc_ok, rw_ok;
	always_comb begin
		base = window[cpu_state_pkg::WIN_BASE_LO +: 8];
		mask = window[cpu_state_pkg::WIN_MASK_LO +: 8];
		fc_base = window[cpu_state_pkg::WIN_FC_BASE_LO +: 3];
		fc_mask = window[cpu_state_pkg::WIN_FC_MASK_LO +: 3];
		// mask ones mark bits that never take part in the compare
		addr_ok = ((addr_top ^ base) & ~mask) == 8'h00;
		fc_ok = ((space ^ fc_base) & ~fc_mask) == 3'h0;
		// rw bit set selects reads, clear selects writes; rwm lets both through
		rw_ok = window[cpu_state_pkg::WIN_RWM] | (window[cpu_state_pkg::WIN_RW] ^ write);
		hit = window[cpu_state_pkg::WIN_EN] & addr_ok & fc_ok & rw_ok;
	end
endmodule
